/* jtp_pkg.sv */
`default_nettype none
package jtp_pkg;

  // ****************************************
  // widths and lengths
  // ****************************************
  localparam int IR_W      = 8;   // instruction register width
  localparam int DR_W      = 32;  // identification / user code width
  localparam int BSR_LEN   = 8;   // boundary cells, one per pad
  localparam int SYNC_W    = 6;   // number of synchronised pins
  localparam int FIFO_W    = 8;   // stream word width
  localparam int FIFO_D    = 16;  // stream buffer depth
  localparam int BIT_CNT_W = 3;   // bits per stream word counter

  // ****************************************
  // instruction codes
  // ****************************************
  localparam logic [7:0] OP_EXTEST   = 8'h00;
  localparam logic [7:0] OP_SAMPLE   = 8'h01;
  localparam logic [7:0] OP_CLAMP    = 8'h05;
  localparam logic [7:0] OP_HIGHZ    = 8'h07;
  localparam logic [7:0] OP_USERCODE = 8'h0E;
  localparam logic [7:0] OP_IDCODE   = 8'h0F;
  localparam logic [7:0] OP_BYPASS   = 8'hFF;
  localparam logic [7:0] OP_USER_LO  = 8'h10;  // 16
  localparam logic [7:0] OP_USER_HI  = 8'h7F;  // 127

  // ****************************************
  // reset and capture values
  // ****************************************
  localparam logic [7:0]  IR_RST      = OP_IDCODE;   // after reset state
  localparam logic [7:0]  IR_CAPTURE  = 8'h01;       // fixed capture pattern
  localparam logic [31:0] IDCODE_VAL  = 32'h0000_0001; // arbitrary value
  localparam logic [31:0] USERCODE_VAL = 32'h0000_0000; // arbitrary value
  localparam logic [2:0]  BIT_CNT_RST = 3'h0;
  localparam logic [2:0]  BIT_CNT_LAST = 3'h7;

  // ****************************************
  // tap controller states
  // ****************************************
  typedef enum logic [3:0] {
    ST_TLR    = 4'h0,
    ST_RTI    = 4'h1,
    ST_SEL_DR = 4'h2,
    ST_CAP_DR = 4'h3,
    ST_SH_DR  = 4'h4,
    ST_EX1_DR = 4'h5,
    ST_PA_DR  = 4'h6,
    ST_EX2_DR = 4'h7,
    ST_UPD_DR = 4'h8,
    ST_SEL_IR = 4'h9,
    ST_CAP_IR = 4'hA,
    ST_SH_IR  = 4'hB,
    ST_EX1_IR = 4'hC,
    ST_PA_IR  = 4'hD,
    ST_EX2_IR = 4'hE,
    ST_UPD_IR = 4'hF
  } jtp_state_type;

endpackage : jtp_pkg
`default_nettype wire

/* jtp_sync.sv */
`default_nettype none
// ****************************************
// two flop synchroniser for pin inputs
// ****************************************
module jtp_sync #(
  parameter int W = 1
) (
  input  wire logic         ref_clk,
  input  wire logic         sys_rst,
  input  wire logic         clk_en,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  typedef struct packed {
    logic [W-1:0] s1;  // first stage, read by s2 only
    logic [W-1:0] s2;  // second stage, safe to use
  } jtp_sync_type;

  jtp_sync_type st_r;
  jtp_sync_type st_nxt;

  // shift the pins through both stages
  always_comb
  begin
    st_nxt    = st_r;
    st_nxt.s1 = async_in;
    st_nxt.s2 = st_r.s1;
  end

  // state register, frozen while clock enable is low
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      st_r <= '0;
    end
    else if (clk_en)
    begin
      st_r <= st_nxt;
    end
  end

  assign sync_out = st_r.s2;

endmodule : jtp_sync
`default_nettype wire

/* jtp_fifo.sv */
`default_nettype none
// ****************************************
// stream buffer with valid/ready both sides
// ****************************************
module jtp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input  wire logic             ref_clk,
  input  wire logic             sys_rst,
  input  wire logic             clk_en,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic      [WIDTH-1:0] out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);

  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;  // storage words
    logic [AW:0]                 wp;   // write pointer, wrap bit on top
    logic [AW:0]                 rp;   // read pointer, wrap bit on top
  } jtp_fifo_type;

  jtp_fifo_type st_r;
  jtp_fifo_type st_nxt;
  logic         full;
  logic         empty;

  // full when pointers differ only in the wrap bit
  assign full      = (st_r.wp[AW] != st_r.rp[AW]) &&
                     (st_r.wp[AW-1:0] == st_r.rp[AW-1:0]);
  assign empty     = (st_r.wp == st_r.rp);
  assign in_ready  = ~full;
  assign out_valid = ~empty;
  assign out_data  = st_r.mem[st_r.rp[AW-1:0]];

  // write and read bookkeeping
  always_comb
  begin
    st_nxt = st_r;
    if (in_valid && !full)
    begin
      st_nxt.mem[st_r.wp[AW-1:0]] = in_data;
      st_nxt.wp = st_r.wp + 1'b1;
    end
    if (out_ready && !empty)
    begin
      st_nxt.rp = st_r.rp + 1'b1;
    end
  end

  // state register
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      st_r <= '0;
    end
    else if (clk_en)
    begin
      st_r <= st_nxt;
    end
  end

endmodule : jtp_fifo
`default_nettype wire

/* jtp_tap.sv */
// Summary of operation
// - no test access straight out of freeze
// - extest 00, sample 01, bypass FF decoded
// - idcode 0F, usercode 0E, highz 07, clamp 05
// - eight-bit instruction register shown to core
// - codes 16 to 127 are user instructions
// - boundary cells chained from TDI to TDO
// - undriven TMS, TDI, TRST read high
// - reset-state output low in Test-Logic-Reset
// - power-on reset puts controller in reset
// - user serial input follows TDI directly
// - user code routes user serial output out
// - shift strobe high only in Shift-DR
// - capture strobe high only in Capture-DR
// - update strobe high only in Update-DR
// - user data clock is TCK directly
`default_nettype none
module jtp_tap (
  input  wire logic                        ref_clk,
  input  wire logic                        sys_rst,
  input  wire logic                        clk_en,
  input  wire logic                        tck_pin,
  input  wire logic                        tms_pin,
  input  wire logic                        tms_driven,
  input  wire logic                        tdi_pin,
  input  wire logic                        tdi_driven,
  input  wire logic                        trst_n_pin,
  input  wire logic                        trst_driven,
  input  wire logic                        freeze_pin,
  output logic                             tdo_pin,
  output logic                             tdo_oe,
  input  wire logic [jtp_pkg::BSR_LEN-1:0] pad_in,
  input  wire logic [jtp_pkg::BSR_LEN-1:0] core_out,
  input  wire logic [jtp_pkg::BSR_LEN-1:0] core_oe,
  output logic      [jtp_pkg::BSR_LEN-1:0] pad_out,
  output logic      [jtp_pkg::BSR_LEN-1:0] pad_oe,
  output logic      [jtp_pkg::IR_W-1:0]    user_instruction_bus,
  output logic                             user_tap_reset_state_n,
  output logic                             user_serial_in,
  input  wire logic                        user_serial_out,
  output logic                             user_shift_strobe,
  output logic                             user_capture_strobe,
  output logic                             user_update_strobe,
  output logic                             user_dr_clock,
  output logic      [jtp_pkg::FIFO_W-1:0]  user_stream_data,
  output logic                             user_stream_valid,
  input  wire logic                        user_stream_ready
);

  // ****************************************
  // state record
  // ****************************************
  typedef struct packed {
    jtp_pkg::jtp_state_type          st;       // controller state
    logic [jtp_pkg::IR_W-1:0]        ir;       // active instruction
    logic [jtp_pkg::IR_W-1:0]        ir_sh;    // instruction shifter
    logic [jtp_pkg::DR_W-1:0]        dr_sh;    // code shifter
    logic [jtp_pkg::BSR_LEN-1:0]     bsr_sh;   // boundary shift stage
    logic [jtp_pkg::BSR_LEN-1:0]     bsr_upd;  // boundary update stage
    logic                            byp;      // bypass bit
    logic                            tdo;      // registered tdo
    logic                            tdo_oe;   // tdo drive enable
    logic                            tck_d;    // last synced tck
    logic                            lock;     // held after freeze
    logic [jtp_pkg::FIFO_W-1:0]      ub_sh;    // user stream assembler
    logic [jtp_pkg::BIT_CNT_W-1:0]   ub_cnt;   // bits in assembler
    logic                            pend;     // word waiting to push
    logic [jtp_pkg::FIFO_W-1:0]      pend_d;   // waiting word
  } jtp_main_type;

  jtp_main_type st_r;
  jtp_main_type st_nxt;

  // ****************************************
  // helpers
  // ****************************************
  // standard controller transition
  function automatic jtp_pkg::jtp_state_type jtp_next(
    input jtp_pkg::jtp_state_type s,
    input logic                   tms
  );
    jtp_pkg::jtp_state_type n;
    n = s;
    unique case (s)
      jtp_pkg::ST_TLR:    n = tms ? jtp_pkg::ST_TLR    : jtp_pkg::ST_RTI;
      jtp_pkg::ST_RTI:    n = tms ? jtp_pkg::ST_SEL_DR : jtp_pkg::ST_RTI;
      jtp_pkg::ST_SEL_DR: n = tms ? jtp_pkg::ST_SEL_IR : jtp_pkg::ST_CAP_DR;
      jtp_pkg::ST_CAP_DR: n = tms ? jtp_pkg::ST_EX1_DR : jtp_pkg::ST_SH_DR;
      jtp_pkg::ST_SH_DR:  n = tms ? jtp_pkg::ST_EX1_DR : jtp_pkg::ST_SH_DR;
      jtp_pkg::ST_EX1_DR: n = tms ? jtp_pkg::ST_UPD_DR : jtp_pkg::ST_PA_DR;
      jtp_pkg::ST_PA_DR:  n = tms ? jtp_pkg::ST_EX2_DR : jtp_pkg::ST_PA_DR;
      jtp_pkg::ST_EX2_DR: n = tms ? jtp_pkg::ST_UPD_DR : jtp_pkg::ST_SH_DR;
      jtp_pkg::ST_UPD_DR: n = tms ? jtp_pkg::ST_SEL_DR : jtp_pkg::ST_RTI;
      jtp_pkg::ST_SEL_IR: n = tms ? jtp_pkg::ST_TLR    : jtp_pkg::ST_CAP_IR;
      jtp_pkg::ST_CAP_IR: n = tms ? jtp_pkg::ST_EX1_IR : jtp_pkg::ST_SH_IR;
      jtp_pkg::ST_SH_IR:  n = tms ? jtp_pkg::ST_EX1_IR : jtp_pkg::ST_SH_IR;
      jtp_pkg::ST_EX1_IR: n = tms ? jtp_pkg::ST_UPD_IR : jtp_pkg::ST_PA_IR;
      jtp_pkg::ST_PA_IR:  n = tms ? jtp_pkg::ST_EX2_IR : jtp_pkg::ST_PA_IR;
      jtp_pkg::ST_EX2_IR: n = tms ? jtp_pkg::ST_UPD_IR : jtp_pkg::ST_SH_IR;
      jtp_pkg::ST_UPD_IR: n = tms ? jtp_pkg::ST_SEL_DR : jtp_pkg::ST_RTI;
    endcase
    return n;
  endfunction : jtp_next

  // user range decode, used by tdo mux and stream
  function automatic logic jtp_is_user(input logic [7:0] ir);
    return (ir >= jtp_pkg::OP_USER_LO) && (ir <= jtp_pkg::OP_USER_HI);
  endfunction : jtp_is_user

  // boundary register selected
  function automatic logic jtp_is_bsr(input logic [7:0] ir);
    return (ir == jtp_pkg::OP_EXTEST) || (ir == jtp_pkg::OP_SAMPLE);
  endfunction : jtp_is_bsr

  // ****************************************
  // pins: pull-ups, passthroughs, sync
  // ****************************************
  logic                      tms_eff;   // tms with pull-up
  logic                      tdi_eff;   // tdi with pull-up
  logic                      trst_eff;  // trst with pull-up
  logic [jtp_pkg::SYNC_W-1:0] pins_s;   // synchronised pins
  logic                      tck_s;
  logic                      tms_s;
  logic                      tdi_s;
  logic                      trst_n_s;
  logic                      frz_s;
  logic                      uso_s;

  // undriven inputs read as high
  assign tms_eff  = tms_driven  ? tms_pin    : 1'b1;
  assign tdi_eff  = tdi_driven  ? tdi_pin    : 1'b1;
  assign trst_eff = trst_driven ? trst_n_pin : 1'b1;

  // straight wires to the core side
  assign user_serial_in = tdi_eff;
  assign user_dr_clock  = tck_pin;

  jtp_sync #(
    .W (jtp_pkg::SYNC_W)
  ) u_sync (
    .ref_clk  (ref_clk),
    .sys_rst  (sys_rst),
    .clk_en   (clk_en),
    .async_in ({tck_pin, tms_eff, tdi_eff, trst_eff, freeze_pin,
                user_serial_out}),
    .sync_out (pins_s)
  );

  assign {tck_s, tms_s, tdi_s, trst_n_s, frz_s, uso_s} = pins_s;

  // ****************************************
  // stream buffer toward the core
  // ****************************************
  logic fifo_in_ready;  // buffer can take a word
  logic stall;          // word waiting and buffer full
  logic tck_rise;
  logic tck_fall;
  logic step;           // controller advances this cycle

  jtp_fifo #(
    .WIDTH (jtp_pkg::FIFO_W),
    .DEPTH (jtp_pkg::FIFO_D)
  ) u_fifo (
    .ref_clk   (ref_clk),
    .sys_rst   (sys_rst),
    .clk_en    (clk_en),
    .in_data   (st_r.pend_d),
    .in_valid  (st_r.pend),
    .in_ready  (fifo_in_ready),
    .out_data  (user_stream_data),
    .out_valid (user_stream_valid),
    .out_ready (user_stream_ready)
  );

  // back-pressure holds the controller still
  assign stall    = st_r.pend & ~fifo_in_ready;
  assign tck_rise = tck_s & ~st_r.tck_d;
  assign tck_fall = ~tck_s & st_r.tck_d;
  assign step     = tck_rise & ~stall;

  // ****************************************
  // tdo source select
  // ****************************************
  logic dr_bit;  // bit leaving the selected register

  always_comb
  begin
    if (jtp_is_user(st_r.ir))
    begin
      dr_bit = uso_s;
    end
    else if (jtp_is_bsr(st_r.ir))
    begin
      dr_bit = st_r.bsr_sh[jtp_pkg::BSR_LEN-1];
    end
    else if ((st_r.ir == jtp_pkg::OP_IDCODE) ||
             (st_r.ir == jtp_pkg::OP_USERCODE))
    begin
      dr_bit = st_r.dr_sh[0];
    end
    else
    begin
      dr_bit = st_r.byp;
    end
  end

  // ****************************************
  // next state
  // ****************************************
  always_comb
  begin
    st_nxt       = st_r;
    st_nxt.tck_d = tck_s;
    // push the waiting word once the buffer takes it
    if (st_r.pend && fifo_in_ready)
    begin
      st_nxt.pend = 1'b0;
    end
    // freeze holds the controller and arms a lock
    if (frz_s)
    begin
      st_nxt.lock = 1'b1;
      st_nxt.st   = jtp_pkg::ST_TLR;
      st_nxt.ir   = jtp_pkg::IR_RST;
    end
    else if (!trst_n_s)
    begin
      // test reset pin forces reset state
      st_nxt.st = jtp_pkg::ST_TLR;
      st_nxt.ir = jtp_pkg::IR_RST;
    end
    else if (step && st_r.lock)
    begin
      // first edge after freeze only leaves the freeze
      st_nxt.lock = 1'b0;
    end
    else if (step)
    begin
      st_nxt.st = jtp_next(st_r.st, tms_s);
      if (st_nxt.st == jtp_pkg::ST_TLR)
      begin
        st_nxt.ir = jtp_pkg::IR_RST;  // entering reset
      end
      unique case (st_r.st)
        jtp_pkg::ST_CAP_IR:
        begin
          st_nxt.ir_sh = jtp_pkg::IR_CAPTURE;
        end
        jtp_pkg::ST_SH_IR:
        begin
          st_nxt.ir_sh = {tdi_s, st_r.ir_sh[jtp_pkg::IR_W-1:1]};
        end
        jtp_pkg::ST_UPD_IR:
        begin
          st_nxt.ir = st_r.ir_sh;
        end
        jtp_pkg::ST_CAP_DR:
        begin
          st_nxt.byp    = 1'b0;
          st_nxt.ub_cnt = jtp_pkg::BIT_CNT_RST;
          st_nxt.bsr_sh = pad_in;
          if (st_r.ir == jtp_pkg::OP_IDCODE)
          begin
            st_nxt.dr_sh = jtp_pkg::IDCODE_VAL;
          end
          else if (st_r.ir == jtp_pkg::OP_USERCODE)
          begin
            st_nxt.dr_sh = jtp_pkg::USERCODE_VAL;
          end
        end
        jtp_pkg::ST_SH_DR:
        begin
          st_nxt.byp   = tdi_s;
          st_nxt.dr_sh = {tdi_s, st_r.dr_sh[jtp_pkg::DR_W-1:1]};
          // first cell fed from tdi, last cell toward tdo
          st_nxt.bsr_sh = {st_r.bsr_sh[jtp_pkg::BSR_LEN-2:0],
                           tdi_s};
          // user words collect into the stream buffer
          if (jtp_is_user(st_r.ir))
          begin
            st_nxt.ub_sh  = {tdi_s, st_r.ub_sh[jtp_pkg::FIFO_W-1:1]};
            st_nxt.ub_cnt = st_r.ub_cnt + 1'b1;
            if (st_r.ub_cnt == jtp_pkg::BIT_CNT_LAST)
            begin
              st_nxt.pend   = 1'b1;
              st_nxt.pend_d = {tdi_s, st_r.ub_sh[jtp_pkg::FIFO_W-1:1]};
            end
          end
        end
        jtp_pkg::ST_UPD_DR:
        begin
          if (jtp_is_bsr(st_r.ir))
          begin
            st_nxt.bsr_upd = st_r.bsr_sh;
          end
        end
        default:
        begin
          st_nxt.byp = st_r.byp;
        end
      endcase
    end
    // tdo changes on the falling test clock
    if (tck_fall)
    begin
      st_nxt.tdo    = (st_r.st == jtp_pkg::ST_SH_IR) ? st_r.ir_sh[0]
                                                      : dr_bit;
      st_nxt.tdo_oe = (st_r.st == jtp_pkg::ST_SH_IR) ||
                      (st_r.st == jtp_pkg::ST_SH_DR);
    end
  end

  // ****************************************
  // state register
  // ****************************************
  // power-on reset lands in test-logic-reset
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      st_r        <= '0;
      st_r.st     <= jtp_pkg::ST_TLR;
      st_r.ir     <= jtp_pkg::IR_RST;
      st_r.ub_cnt <= jtp_pkg::BIT_CNT_RST;
      st_r.tck_d  <= 1'b0;
    end
    else if (clk_en)
    begin
      st_r <= st_nxt;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  logic mode_drive;  // boundary cells drive pads
  logic mode_highz;  // all pads released

  assign mode_drive = (st_r.ir == jtp_pkg::OP_EXTEST) ||
                      (st_r.ir == jtp_pkg::OP_CLAMP);
  assign mode_highz = (st_r.ir == jtp_pkg::OP_HIGHZ);

  // one pad output stage per boundary cell
  genvar gi;
  generate
    for (gi = 0; gi < jtp_pkg::BSR_LEN; gi++)
    begin : g_pad
      assign pad_out[gi] = mode_drive ? st_r.bsr_upd[gi] : core_out[gi];
      assign pad_oe[gi]  = mode_highz ? 1'b0 :
                           (mode_drive ? 1'b1 : core_oe[gi]);
    end
  endgenerate

  assign tdo_pin              = st_r.tdo;
  assign tdo_oe               = st_r.tdo_oe;
  assign user_instruction_bus = st_r.ir;
  assign user_tap_reset_state_n =
    (st_r.st != jtp_pkg::ST_TLR);
  assign user_shift_strobe    = (st_r.st == jtp_pkg::ST_SH_DR);
  assign user_capture_strobe  = (st_r.st == jtp_pkg::ST_CAP_DR);
  assign user_update_strobe   = (st_r.st == jtp_pkg::ST_UPD_DR);

endmodule : jtp_tap
`default_nettype wire

/* jtp_tap_monitor.sv */
`default_nettype none
// ****************************************
// port checker for the test access port
// ****************************************
module jtp_tap_monitor (
  input wire logic                     ref_clk,
  input wire logic                     sys_rst,
  input wire logic                     tck_pin,
  input wire logic                     tdi_pin,
  input wire logic                     tdi_driven,
  input wire logic                     freeze_pin,
  input wire logic                     tdo_pin,
  input wire logic [jtp_pkg::IR_W-1:0] user_instruction_bus,
  input wire logic                     user_tap_reset_state_n,
  input wire logic                     user_serial_in,
  input wire logic                     user_shift_strobe,
  input wire logic                     user_capture_strobe,
  input wire logic                     user_update_strobe,
  input wire logic                     user_dr_clock
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  // at most one data register strobe at a time
  strobe_onehot_a: assert property ($onehot0({user_shift_strobe,
    user_capture_strobe, user_update_strobe}))
    else $error("more than one user strobe high");
  // no strobe while in the reset state
  reset_quiet_a: assert property (!user_tap_reset_state_n |->
    !(user_shift_strobe || user_capture_strobe || user_update_strobe))
    else $error("strobe high in reset state");
  // serial input passes the pin, pulled high when undriven
  serial_in_a: assert property (
    user_serial_in == (tdi_driven ? tdi_pin : 1'h1))
    else $error("user serial input differs from tdi");
  // data register clock is the test clock itself
  dr_clock_a: assert property (user_dr_clock == tck_pin)
    else $error("user dr clock differs from tck");
  // controller stays in reset for two clocks after power-on reset
  por_reset_a: assert property ($fell(sys_rst) |->
    !user_tap_reset_state_n [*2])
    else $error("reset state not held after reset");
  // update state lasts at least six reference clocks
  update_hold_a: assert property ($rose(user_update_strobe) |->
    user_update_strobe [*6])
    else $error("update strobe too short");
  // shift state entered only on a test clock rise
  shift_on_rise_a: assert property ($rose(user_shift_strobe) |->
    $past(tck_pin, 2))
    else $error("shift strobe rose without tck rise");
  // tdo moves only after a falling test clock
  tdo_on_fall_a: assert property ($changed(tdo_pin) |->
    !$past(tck_pin, 2))
    else $error("tdo changed while tck high");
  // freeze holds the controller in reset
  freeze_hold_a: assert property (freeze_pin [*4] |->
    !user_tap_reset_state_n)
    else $error("controller left reset during freeze");
  // reset state reloads the default instruction
  ir_reset_a: assert property (!user_tap_reset_state_n [*2] |->
    user_instruction_bus == jtp_pkg::IR_RST)
    else $error("instruction not reset in reset state");
  cap_seen_c: cover property (user_capture_strobe);
  upd_seen_c: cover property ($rose(user_update_strobe));
  frz_seen_c: cover property (freeze_pin && !user_tap_reset_state_n);
endmodule : jtp_tap_monitor
bind jtp_tap jtp_tap_monitor u_mon (.ref_clk, .sys_rst, .tck_pin, .tdi_pin,
  .tdi_driven, .freeze_pin, .tdo_pin, .user_instruction_bus,
  .user_tap_reset_state_n, .user_serial_in, .user_shift_strobe,
  .user_capture_strobe, .user_update_strobe, .user_dr_clock);
`default_nettype wire

/* jtp_host_model.sv */
`default_nettype none
// ****************************************
// jtag host, one tck period per request
// ****************************************
module jtp_host_model (
  input  wire logic ref_clk,
  input  wire logic req,
  input  wire logic tms_bit,
  input  wire logic tdi_bit,
  input  wire logic tdo_pin,
  output var logic  tck_pin,
  output var logic  tms_pin,
  output var logic  tdi_pin,
  output var logic  tdo_bit,
  output var logic  done
);
  timeunit 1ns;
  timeprecision 100ps;
  // tck stands low between requests; back to back it runs 4 low, 4 high
  initial
  begin
    tck_pin = 1'h0;
    tms_pin = 1'h1;
    tdi_pin = 1'h1;
    tdo_bit = 1'h0;
    done = 1'h0;
    forever
    begin
      @(posedge ref_clk);
      done <= 1'h0;
      if (req && !done)
      begin
        tms_pin <= tms_bit;
        tdi_pin <= tdi_bit;
        // the handshake already spent three cycles of the low phase
        @(posedge ref_clk);
        // tdo read just before the rise, set on the last fall
        tdo_bit <= tdo_pin;
        tck_pin <= 1'h1;
        repeat (4) @(posedge ref_clk);
        tck_pin <= 1'h0;
        done <= 1'h1;
      end
    end
  end
endmodule : jtp_host_model
`default_nettype wire

/* jtag_tap_with_user_port_tb.sv */
`default_nettype none
module jtag_tap_with_user_port_tb;
  timeunit 1ns;
  timeprecision 100ps;
  // ****************************************
  // nets, design and host
  // ****************************************
  logic         ref_clk, sys_rst, req, tms_b, tdi_b, tdo_b, done;
  logic         tck, tms, tdi, tdo, frz, trst_n, tms_drv, tdi_drv, trst_drv;
  logic         uso, rdy, svalid, rst_st_n;
  logic [7:0]   ir_bus, sdata, poe;
  logic [127:0] got;
  int           n_fail, total_checks;
  jtp_tap u_dut (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .clk_en(1'h1),
    .tck_pin(tck), .tms_pin(tms), .tms_driven(tms_drv),
    .tdi_pin(tdi), .tdi_driven(tdi_drv), .trst_n_pin(trst_n),
    .trst_driven(trst_drv), .freeze_pin(frz), .tdo_pin(tdo), .tdo_oe(),
    .pad_in(8'h5A), .core_out(8'h00), .core_oe(8'hFF), .pad_out(),
    .pad_oe(poe), .user_instruction_bus(ir_bus),
    .user_tap_reset_state_n(rst_st_n), .user_serial_in(),
    .user_serial_out(uso), .user_shift_strobe(), .user_capture_strobe(),
    .user_update_strobe(), .user_dr_clock(), .user_stream_data(sdata),
    .user_stream_valid(svalid), .user_stream_ready(rdy));
  jtp_host_model u_host (.ref_clk(ref_clk), .req(req), .tms_bit(tms_b),
    .tdi_bit(tdi_b), .tdo_pin(tdo), .tck_pin(tck), .tms_pin(tms),
    .tdi_pin(tdi), .tdo_bit(tdo_b), .done(done));
  always #20 ref_clk = ~ref_clk;
  // ****************************************
  // shared tasks
  // ****************************************
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : tally_and_finish
  task automatic chk(input string nm, input logic [127:0] e,
                     input logic [127:0] g);
    total_checks++;
    if (g !== e)
    begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // one tck period, held until the host reports done
  task automatic step(input logic m, input logic d);
    int i;
    @(posedge ref_clk);
    req <= 1'h1;
    tms_b <= m;
    tdi_b <= d;
    for (i = 0; i < 40 && done !== 1'h1; i++)
      @(posedge ref_clk);
    if (done !== 1'h1)
    begin
      n_fail++;
      tally_and_finish();
    end
    req <= 1'h0;
  endtask : step
  // idle to shift, n bits lsb first, update, back to idle
  task automatic scan(input bit ir, input int n, input logic [127:0] d);
    int k;
    got = '0;
    step(1'h1, 1'h0);
    if (ir)
      step(1'h1, 1'h0);
    step(1'h0, 1'h0);
    step(1'h0, 1'h0);
    for (k = 0; k < n; k++)
    begin
      step(k == n - 1, d[k]);
      got[k] = tdo_b;
    end
    step(1'h1, 1'h0);
    step(1'h0, 1'h0);
  endtask : scan
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_codes();
    logic [7:0] ops [9] = '{jtp_pkg::OP_EXTEST, jtp_pkg::OP_SAMPLE,
      jtp_pkg::OP_CLAMP, jtp_pkg::OP_HIGHZ, jtp_pkg::OP_USERCODE,
      jtp_pkg::OP_IDCODE, jtp_pkg::OP_BYPASS, 8'h10, 8'h7F};
    chk("reset_n", 0, rst_st_n);
    chk("ir_rst", jtp_pkg::IR_RST, ir_bus);
    step(1'h0, 1'h0);
    chk("reset_n", 1, rst_st_n);
    foreach (ops[i])
    begin
      scan(1, 8, ops[i]);
      chk("ir_bus", ops[i], ir_bus);
      chk("ir_cap", jtp_pkg::IR_CAPTURE, got[7:0]);
      chk("pad_oe", {8{ops[i] != jtp_pkg::OP_HIGHZ}}, poe);
    end
    scan(1, 8, jtp_pkg::OP_BYPASS);
    scan(0, 8, 8'hA5);
    chk("bypass", 8'h4A, got[7:0]);
    scan(1, 8, jtp_pkg::OP_IDCODE);
    scan(0, 32, 0);
    chk("idcode", jtp_pkg::IDCODE_VAL, got[31:0]);
    scan(1, 8, jtp_pkg::OP_USERCODE);
    scan(0, 32, 0);
    chk("usercode", jtp_pkg::USERCODE_VAL, got[31:0]);
    scan(1, 8, jtp_pkg::OP_SAMPLE);
    scan(0, 16, 16'h00C3);
    chk("chain", 16'hC35A, got[15:0]);
    $display("codes and chains done");
  endtask : t_codes
  task automatic t_user();
    logic [127:0] d;
    int i;
    uso <= 1'h1;
    for (i = 0; i < 16; i++)
      d[i*8 +: 8] = 8'hA0 + 8'(i);
    scan(1, 8, 8'h10);
    scan(0, 128, d);
    chk("user_tdo", {128{1'h1}}, got);
    for (i = 0; i < 16; i++)
    begin
      chk("valid", 1, svalid);
      chk("word", d[i*8 +: 8], sdata);
      rdy <= 1'h1;
      @(posedge ref_clk);
      rdy <= 1'h0;
      @(posedge ref_clk);
    end
    chk("empty", 0, svalid);
    $display("user stream done");
  endtask : t_user
  task automatic t_resets();
    tms_drv <= 1'h0;
    tdi_drv <= 1'h0;
    repeat (5) step(1'h0, 1'h0);
    chk("pullup", 0, rst_st_n);
    tms_drv <= 1'h1;
    tdi_drv <= 1'h1;
    step(1'h0, 1'h0);
    scan(1, 8, 8'h10);
    trst_n <= 1'h0;
    repeat (8) @(posedge ref_clk);
    chk("trst", {1'h0, jtp_pkg::IR_RST}, {rst_st_n, ir_bus});
    trst_n <= 1'h1;
    step(1'h0, 1'h0);
    trst_drv <= 1'h0;
    trst_n <= 1'h0;
    repeat (8) @(posedge ref_clk);
    chk("trst_pull", 1, rst_st_n);
    {trst_n, trst_drv} <= 2'h3;
    frz <= 1'h1;
    repeat (2) step(1'h0, 1'h0);
    chk("frozen", 0, rst_st_n);
    frz <= 1'h0;
    step(1'h0, 1'h0);
    chk("unlock", 0, rst_st_n);
    step(1'h0, 1'h0);
    chk("leave", 1, rst_st_n);
    $display("resets and freeze done");
  endtask : t_resets
  initial
  begin
    ref_clk = 1'h0;
    sys_rst = 1'h1;
    {req, tms_b, tdi_b, frz, uso, rdy} = 6'h00;
    {trst_n, tms_drv, tdi_drv, trst_drv} = 4'hF;
    n_fail = 0;
    total_checks = 0;
    repeat (8) @(posedge ref_clk);
    sys_rst <= 1'h0;
    repeat (3) @(posedge ref_clk);
    t_codes();
    t_user();
    t_resets();
    tally_and_finish();
  end
endmodule : jtag_tap_with_user_port_tb
`default_nettype wire
